// ---- dv/rc_autocal_failure_control_bench.sv ----
// Self-checking bench for the RC autocalibration failure control block.
// Seconds are fast ticks; the crystal runs whenever it is powered and healthy.
`timescale 1ns/1ps
module rc_autocal_failure_control_bench;
    localparam logic [7:0] CT = rcacf_pkg::ADDR_OSC_CTRL;
    localparam logic [7:0] ST = rcacf_pkg::ADDR_OSC_STAT;
    logic ref_clk_i, resetn_i, sec_tick_i, xtal_fail_i, meas_done_i, xt_ok, ok;
    logic signed [rcacf_pkg::ADJ_W-1:0] meas_adj_i;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic reg_wr_i, reg_rd_i, xtal_en_o, use_rc_o, cal_busy_o, irq_o, xtal_running_i;
    int num_errors = 0;
    int check_count = 0;
    assign xtal_running_i = xt_ok & xtal_en_o;
    rcacf_ctrl #(.ADJ_W(rcacf_pkg::ADJ_W)) u_rcacf_ctrl (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .sec_tick_i(sec_tick_i), .xtal_running_i(xtal_running_i),
        .xtal_fail_i(xtal_fail_i), .meas_done_i(meas_done_i), .meas_adj_i(meas_adj_i),
        .xtal_en_o(xtal_en_o), .use_rc_o(use_rc_o), .cal_busy_o(cal_busy_o), .irq_o(irq_o));
    rcacf_host_model u_rcacf_host_model (.ref_clk_i(ref_clk_i), .reg_rdata_i(reg_rdata_o),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_rcacf_host_model.rd(a, d);
        chk(what, exp, d);
    endtask
    task automatic step();
        @(posedge ref_clk_i);
        #1;
    endtask
    // Extra cycle after each tick so tick-launched updates have landed
    task automatic tick(input int n);
        repeat (n) begin
            step();
            sec_tick_i = 1'b1;
            step();
            sec_tick_i = 1'b0;
            step();
        end
    endtask
    task automatic meas(input logic signed [rcacf_pkg::ADJ_W-1:0] a);
        step();
        meas_done_i = 1'b1;
        meas_adj_i = a;
        step();
        meas_done_i = 1'b0;
        step();
    endtask
    task automatic t_reset();
        rchk("ctrl", CT, 8'h00);
        rchk("stat", ST, 8'h80);
        rchk("unmapped", 8'h3F, 8'h00);
        chk("irq", 8'h00, irq_o);
        u_rcacf_host_model.wr(8'h15, 8'h5A);
        rchk("trim_up", 8'h15, 8'h5A);
        $display("t_reset done");
    endtask
    task automatic t_fail();
        logic signed [rcacf_pkg::ADJ_W-1:0] adj [2] = '{20'sd65535, -20'sd65536};
        logic [15:0] tr [2] = '{16'hDFFF, 16'hE000};
        u_rcacf_host_model.wr(CT, 8'hE1);
        step();
        chk("busy", 8'h01, cal_busy_o);
        chk("xt_en", 8'h01, xtal_en_o);
        for (int i = 0; i < 2; i++) begin
            meas(adj[i]);
            rchk("trim_up", 8'h15, tr[i][15:8]);
            rchk("trim_lo", 8'h16, tr[i][7:0]);
        end
        meas(-20'sd65537);
        rchk("stat", ST, 8'h81);
        chk("irq", 8'h01, irq_o);
        rchk("trim_up", 8'h15, 8'hE0);
        rchk("trim_lo", 8'h16, 8'h00);
        tick(49);
        chk("busy", 8'h01, cal_busy_o);
        chk("irq", 8'h01, irq_o);
        tick(1);
        chk("busy", 8'h00, cal_busy_o);
        chk("xt_en", 8'h00, xtal_en_o);
        $display("t_fail done");
    endtask
    task automatic t_mask();
        u_rcacf_host_model.arm_retry(8'hE1);
        chk("irq", 8'h00, irq_o);
        u_rcacf_host_model.wr(CT, 8'h80);
        u_rcacf_host_model.wr(CT, 8'hE0);
        meas(20'sd65536);
        rchk("stat", ST, 8'h81);
        chk("irq", 8'h00, irq_o);
        u_rcacf_host_model.wr(CT, 8'hE1);
        step();
        chk("irq", 8'h01, irq_o);
        u_rcacf_host_model.arm_retry(8'hE1);
        chk("irq", 8'h00, irq_o);
        $display("t_mask done");
    endtask
    task automatic t_period();
        logic [1:0] code [2] = '{rcacf_pkg::INTERVAL_512, rcacf_pkg::INTERVAL_1024};
        int len [2] = '{512, 1024};
        u_rcacf_host_model.wr(CT, 8'h80);
        tick(50);
        u_rcacf_host_model.wr(CT, 8'hA0);
        tick(2);
        chk("busy_rsvd", 8'h00, cal_busy_o);
        for (int i = 0; i < 2; i++) begin
            u_rcacf_host_model.wr(CT, 8'h80);
            u_rcacf_host_model.wr(CT, {1'b1, code[i], 5'h00});
            tick(len[i] - 1);
            chk("busy_pre", 8'h00, cal_busy_o);
            tick(1);
            chk("busy_start", 8'h01, cal_busy_o);
        end
        $display("t_period done");
    endtask
    task automatic t_osc();
        tick(1);
        chk("rc_in_cal", 8'h01, use_rc_o);
        u_rcacf_host_model.to_xtal(8'hC0, ok);
        chk("xt_ok", 8'h01, ok);
        chk("rc_held", 8'h01, use_rc_o);
        tick(1);
        chk("use_rc", 8'h00, use_rc_o);
        rchk("stat", ST, 8'h00);
        u_rcacf_host_model.try_rc(8'h40, ok);
        tick(1);
        chk("use_rc", 8'h01, use_rc_o);
        u_rcacf_host_model.wr(CT, 8'h40);
        tick(1);
        chk("use_rc_xt", 8'h00, use_rc_o);
        xt_ok = 1'b0;
        xtal_fail_i = 1'b1;
        step();
        xtal_fail_i = 1'b0;
        step();
        chk("rc_fallback", 8'h01, use_rc_o);
        u_rcacf_host_model.to_xtal(8'h40, ok);
        chk("xt_bad", 8'h00, ok);
        $display("t_osc done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    // About 5000 cycles expected; cut off far beyond that
    initial begin
        #400000;
        num_errors++;
        results();
    end
    initial begin
        resetn_i = 1'b0;
        sec_tick_i = 1'b0;
        xtal_fail_i = 1'b0;
        meas_done_i = 1'b0;
        meas_adj_i = '0;
        xt_ok = 1'b1;
        repeat (8) @(posedge ref_clk_i);
        #1;
        resetn_i = 1'b1;
        t_reset();
        t_fail();
        t_mask();
        t_period();
        t_osc();
        results();
    end
endmodule

// ---- dv/rcacf_host_model.sv ----
// Host software model: register port master plus the fallback and return steps.
// Assumes the block's clock; strobes change 1 ns after a rising edge.
`timescale 1ns/1ps
module rcacf_host_model (
    input  wire logic       ref_clk_i,   // Block clock
    input  wire logic [7:0] reg_rdata_i, // Read data from block
    output logic      [7:0] reg_addr_o,  // Register offset
    output logic      [7:0] reg_wdata_o, // Write data
    output logic            reg_wr_o,    // Write strobe
    output logic            reg_rd_o     // Read strobe
);
    initial begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        reg_wr_o = 1'b0;
    endtask
    // Read data is registered, so it is taken after the read edge has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        reg_rd_o = 1'b0;
        d = reg_rdata_i;
    endtask
    // Leave RC mode only with a healthy crystal; interval left as it is
    task automatic to_xtal(input logic [7:0] ctrl, output logic ok);
        logic [7:0] s;
        rd(rcacf_pkg::ADDR_OSC_STAT, s);
        ok = !s[rcacf_pkg::STAT_XT_FAIL_BIT];
        if (ok) begin
            wr(rcacf_pkg::ADDR_OSC_CTRL, ctrl & 8'h7F);
        end
    endtask
    task automatic arm_retry(input logic [7:0] ctrl);
        wr(rcacf_pkg::ADDR_OSC_STAT, 8'h00);
        wr(rcacf_pkg::ADDR_OSC_CTRL, ctrl & 8'hFE);
    endtask
    task automatic try_rc(input logic [7:0] ctrl, output logic back);
        logic [7:0] s;
        rd(rcacf_pkg::ADDR_OSC_STAT, s);
        back = !s[rcacf_pkg::STAT_CAL_FAIL_BIT];
        if (back) begin
            wr(rcacf_pkg::ADDR_OSC_CTRL, ctrl | 8'h80);
        end else begin
            wr(rcacf_pkg::ADDR_OSC_STAT, 8'h00);
        end
    endtask
endmodule

// ---- rtl/rcacf_ctrl.sv ----
// RC autocalibration control with failure handling and oscillator switching.
// Assumes a one-second tick and a measurement engine that reports the
// signed trim adjustment once per calibration, all synchronous to ref_clk_i.
`timescale 1ns/1ps
module rcacf_ctrl #(
    parameter int ADJ_W = rcacf_pkg::ADJ_W
) (
    input  wire logic                    ref_clk_i,    // 50 MHz clock
    input  wire logic                    resetn_i,     // Async reset, active low
    input  wire logic [7:0]              reg_addr_i,   // Register offset
    input  wire logic [7:0]              reg_wdata_i,  // Write data
    input  wire logic                    reg_wr_i,     // Write strobe
    input  wire logic                    reg_rd_i,     // Read strobe
    output logic      [7:0]              reg_rdata_o,  // Read data, registered
    input  wire logic                    sec_tick_i,   // One-second tick
    input  wire logic                    xtal_running_i, // Crystal is oscillating
    input  wire logic                    xtal_fail_i,  // Crystal failure event
    input  wire logic                    meas_done_i,  // Measurement result valid
    input  wire logic signed [ADJ_W-1:0] meas_adj_i,   // Signed trim adjustment
    output logic                         xtal_en_o,    // Crystal power enable
    output logic                         use_rc_o,     // Timebase runs from RC
    output logic                         cal_busy_o,   // Calibration in progress
    output logic                         irq_o         // Failure interrupt, level
);
    typedef struct packed {
        rcacf_pkg::rcacf_cal_t cal;
        logic [5:0]            cal_sec;
        logic [9:0]            per_sec;
        logic [7:0]            trim_upper;
        logic [7:0]            trim_lower;
        logic                  osc_select;
        logic [1:0]            cal_interval;
        logic                  cal_fail_irq_enable;
        logic                  cal_fail_flag;
        logic                  crystal_fail_flag;
        logic                  active_osc_indicator;
        logic [7:0]            rdata;
    } rcacf_state_t;

    rcacf_state_t s_q;
    rcacf_state_t s_d;

    function automatic logic interval_on(input logic [1:0] code);
        interval_on = (code == rcacf_pkg::INTERVAL_1024) || (code == rcacf_pkg::INTERVAL_512);
    endfunction

    // Adjustment below -65536 or above 65535 steps means the RC is off by more than the trim reach
    function automatic logic adj_fails(input logic signed [ADJ_W-1:0] adj);
        adj_fails = (adj < -ADJ_W'(rcacf_pkg::ADJ_LIMIT)) || (adj >= ADJ_W'(rcacf_pkg::ADJ_LIMIT));
    endfunction

    function automatic logic [1:0] adj_range(input logic signed [ADJ_W-1:0] adj);
        if (adj < -ADJ_W'(rcacf_pkg::ADJ_RANGE3) || adj >= ADJ_W'(rcacf_pkg::ADJ_RANGE3)) begin
            adj_range = 2'h3;
        end else if (adj < -ADJ_W'(rcacf_pkg::ADJ_RANGE2) || adj >= ADJ_W'(rcacf_pkg::ADJ_RANGE2)) begin
            adj_range = 2'h2;
        end else if (adj < -ADJ_W'(rcacf_pkg::ADJ_RANGE1) || adj >= ADJ_W'(rcacf_pkg::ADJ_RANGE1)) begin
            adj_range = 2'h1;
        end else begin
            adj_range = 2'h0;
        end
    endfunction

    logic                  ctrl_wr;
    logic                  stat_wr;
    logic                  period_end;
    logic                  cal_start;
    logic                  cal_fail_evt;
    logic                  cal_ok_evt;
    logic [1:0]            new_range;
    logic signed [ADJ_W-1:0] shifted;
    logic [9:0]            per_last;

    always_comb begin
        ctrl_wr      = reg_wr_i && (reg_addr_i == rcacf_pkg::ADDR_OSC_CTRL);
        stat_wr      = reg_wr_i && (reg_addr_i == rcacf_pkg::ADDR_OSC_STAT);
        per_last     = (s_q.cal_interval == rcacf_pkg::INTERVAL_512) ? 10'(rcacf_pkg::PERIOD_SHORT_S - 1)
                                                                     : 10'(rcacf_pkg::PERIOD_LONG_S - 1);
        period_end   = sec_tick_i && interval_on(s_q.cal_interval) && (s_q.per_sec == per_last);
        cal_start    = (s_q.cal == rcacf_pkg::RCACF_IDLE) &&
                       ((ctrl_wr && !interval_on(s_q.cal_interval) &&
                         interval_on(reg_wdata_i[rcacf_pkg::CTRL_INTERVAL_HI:rcacf_pkg::CTRL_INTERVAL_LO])) ||
                        period_end);
        cal_fail_evt = (s_q.cal == rcacf_pkg::RCACF_CAL) && meas_done_i && adj_fails(meas_adj_i);
        cal_ok_evt   = (s_q.cal == rcacf_pkg::RCACF_CAL) && meas_done_i && !adj_fails(meas_adj_i);
        new_range    = adj_range(meas_adj_i);
        shifted      = meas_adj_i >>> new_range;

        s_d = s_q;

        // Period counter restarts whenever the interval is off or reserved
        if (!interval_on(s_q.cal_interval)) begin
            s_d.per_sec = '0;
        end else if (sec_tick_i) begin
            s_d.per_sec = (s_q.per_sec == per_last) ? 10'h000 : s_q.per_sec + 10'h001;
        end

        unique case (s_q.cal)
            rcacf_pkg::RCACF_IDLE: begin
                if (cal_start) begin
                    s_d.cal     = rcacf_pkg::RCACF_CAL;
                    s_d.cal_sec = '0;
                end
            end
            rcacf_pkg::RCACF_CAL: begin
                if (sec_tick_i) begin
                    s_d.cal_sec = s_q.cal_sec + 6'h01;
                end
                if (sec_tick_i && s_q.cal_sec == 6'(rcacf_pkg::XTAL_ON_S - 1)) begin
                    s_d.cal = rcacf_pkg::RCACF_IDLE;
                end
            end
        endcase

        if (cal_ok_evt) begin
            s_d.trim_upper = {new_range, shifted[rcacf_pkg::OFFSET_W-1:8]};
            s_d.trim_lower = shifted[7:0];
        end else if (!cal_fail_evt && reg_wr_i && reg_addr_i == rcacf_pkg::ADDR_TRIM_UPPER) begin
            s_d.trim_upper = reg_wdata_i;
        end else if (!cal_fail_evt && reg_wr_i && reg_addr_i == rcacf_pkg::ADDR_TRIM_LOWER) begin
            s_d.trim_lower = reg_wdata_i;
        end

        if (ctrl_wr) begin
            s_d.osc_select          = reg_wdata_i[rcacf_pkg::CTRL_OSC_SEL_BIT];
            s_d.cal_interval        = reg_wdata_i[rcacf_pkg::CTRL_INTERVAL_HI:rcacf_pkg::CTRL_INTERVAL_LO];
            s_d.cal_fail_irq_enable = reg_wdata_i[rcacf_pkg::CTRL_IRQ_EN_BIT];
        end

        // Write zero clears; a set in the same cycle wins
        if (stat_wr && !reg_wdata_i[rcacf_pkg::STAT_CAL_FAIL_BIT]) begin
            s_d.cal_fail_flag = 1'b0;
        end
        if (cal_fail_evt) begin
            s_d.cal_fail_flag = 1'b1;
        end
        if (stat_wr && !reg_wdata_i[rcacf_pkg::STAT_XT_FAIL_BIT]) begin
            s_d.crystal_fail_flag = 1'b0;
        end
        if (xtal_fail_i) begin
            s_d.crystal_fail_flag = 1'b1;
        end

        // Timebase moves on a second boundary, except that it moves to RC at once when the crystal stops running
        if (s_q.osc_select || !xtal_running_i) begin
            if (sec_tick_i || !xtal_running_i) begin
                s_d.active_osc_indicator = 1'b1;
            end
        end else if (sec_tick_i) begin
            s_d.active_osc_indicator = 1'b0;
        end

        if (reg_rd_i) begin
            unique case (reg_addr_i)
                rcacf_pkg::ADDR_TRIM_UPPER: s_d.rdata = s_q.trim_upper;
                rcacf_pkg::ADDR_TRIM_LOWER: s_d.rdata = s_q.trim_lower;
                rcacf_pkg::ADDR_OSC_CTRL:   s_d.rdata = {s_q.osc_select, s_q.cal_interval, 4'h0,
                                                         s_q.cal_fail_irq_enable};
                rcacf_pkg::ADDR_OSC_STAT:   s_d.rdata = {s_q.active_osc_indicator, 5'h00,
                                                         s_q.crystal_fail_flag, s_q.cal_fail_flag};
                default:                    s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q                      <= '0;
            s_q.cal                  <= rcacf_pkg::RCACF_IDLE;
            s_q.trim_upper           <= rcacf_pkg::TRIM_RESET;
            s_q.trim_lower           <= rcacf_pkg::TRIM_RESET;
            s_q.active_osc_indicator <= rcacf_pkg::ACTIVE_RC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Crystal runs whenever selected, otherwise only during a calibration
    assign xtal_en_o   = !s_q.osc_select || (s_q.cal == rcacf_pkg::RCACF_CAL);
    assign use_rc_o    = s_q.active_osc_indicator;
    assign cal_busy_o  = (s_q.cal == rcacf_pkg::RCACF_CAL);
    assign irq_o       = s_q.cal_fail_flag && s_q.cal_fail_irq_enable;
    assign reg_rdata_o = s_q.rdata;

    a_fail_sets_flag: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        cal_fail_evt |=> s_q.cal_fail_flag)
        else $error("calibration failure did not set flag");

    a_fail_keeps_trim: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        cal_fail_evt |=> ($stable(s_q.trim_upper) && $stable(s_q.trim_lower)))
        else $error("trim changed on failed calibration");

    a_irq_gated_enable: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        irq_o |-> (s_q.cal_fail_flag && s_q.cal_fail_irq_enable))
        else $error("interrupt without flag and enable");

    a_fail_raises_irq: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (cal_fail_evt && s_q.cal_fail_irq_enable && !ctrl_wr) |=> irq_o)
        else $error("enabled calibration failure raised no interrupt");

    a_xt_clears_ind: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (!s_q.osc_select && xtal_running_i && sec_tick_i) |=> !use_rc_o)
        else $error("indicator not cleared after crystal switch");

    a_switch_on_tick: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $fell(use_rc_o) |-> $past(sec_tick_i))
        else $error("timebase switched off a second boundary");

    a_rc_mode_rc: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (s_q.osc_select && $past(s_q.osc_select) && $past(s_q.osc_select, 2) && interval_on(s_q.cal_interval)
         && $past(use_rc_o)) |-> use_rc_o)
        else $error("RC mode left the RC timebase");

    a_period_start: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (period_end && !cal_busy_o) |=> cal_busy_o ##0 s_q.cal_sec == 6'h00)
        else $error("calibration not started at period start");

    a_disabled_idle: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (!interval_on(s_q.cal_interval) && !ctrl_wr && !cal_busy_o) |=> !cal_busy_o)
        else $error("calibration started while disabled");

    a_immediate_start: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (ctrl_wr && !interval_on(s_q.cal_interval) &&
         interval_on(reg_wdata_i[rcacf_pkg::CTRL_INTERVAL_HI:rcacf_pkg::CTRL_INTERVAL_LO]) && !cal_busy_o)
        |=> cal_busy_o)
        else $error("no immediate calibration on enable");

    a_xtal_window: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(cal_busy_o) |-> xtal_en_o ##1 xtal_en_o)
        else $error("crystal not powered during calibration");

    a_flag_holds: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (s_q.cal_fail_flag && !stat_wr) |=> s_q.cal_fail_flag)
        else $error("failure flag dropped without clear");
endmodule

// ---- rtl/rcacf_pkg.sv ----
// Package for the RC autocalibration failure control block.
// Holds register offsets, field positions, reset values and timing constants.
package rcacf_pkg;
    // Register map (byte offsets on the serial register port)
    localparam logic [7:0] ADDR_TRIM_UPPER = 8'h15;
    localparam logic [7:0] ADDR_TRIM_LOWER = 8'h16;
    localparam logic [7:0] ADDR_OSC_CTRL   = 8'h1C;
    localparam logic [7:0] ADDR_OSC_STAT   = 8'h1D;

    // Oscillator control fields
    localparam int CTRL_OSC_SEL_BIT = 7;
    localparam int CTRL_INTERVAL_HI = 6;
    localparam int CTRL_INTERVAL_LO = 5;
    localparam int CTRL_IRQ_EN_BIT  = 0;

    // Oscillator status fields
    localparam int STAT_ACTIVE_BIT  = 7;
    localparam int STAT_XT_FAIL_BIT = 1;
    localparam int STAT_CAL_FAIL_BIT = 0;

    // Calibration interval field codes
    localparam logic [1:0] INTERVAL_OFF  = 2'h0;
    localparam logic [1:0] INTERVAL_RSVD = 2'h1;
    localparam logic [1:0] INTERVAL_1024 = 2'h2;
    localparam logic [1:0] INTERVAL_512  = 2'h3;

    // Periods and crystal on-time, in seconds
    localparam int PERIOD_LONG_S  = 1024;
    localparam int PERIOD_SHORT_S = 512;
    localparam int XTAL_ON_S      = 50;

    // Adjustment limits in trim steps
    localparam int ADJ_W       = 20;
    localparam int ADJ_LIMIT   = 65536;
    localparam int ADJ_RANGE3  = 32768;
    localparam int ADJ_RANGE2  = 16384;
    localparam int ADJ_RANGE1  = 8192;
    localparam int OFFSET_W    = 14;

    // Reset values
    localparam logic [7:0] TRIM_RESET = 8'h00;
    localparam logic       ACTIVE_RC_RESET = 1'b1;

    typedef enum logic {
        RCACF_IDLE,
        RCACF_CAL
    } rcacf_cal_t;
endpackage
